/* verilog/rbc_top.sv */
`timescale 1ns/1ns
`include "rbc_params.svh"

// Overview of operation
// - Measure edge intervals, programmable window and count
// - Two checks per bit: 0/6/12/18 checks
// - Inside window continue, outside go sleep
// - Lower limit min, upper limit max minus one
// - Limits reset to 14 and 24
// - Ignore demodulator in startup, count extended clock
// - Fail on early edge or counter reaching max
// - All checks pass: drive data onto pin
// - Stay receiving until commanded back to polling
// - Output data changes only on extended clock
// - Hold each level, minimum depends on interval
// - Limit data low time to a maximum
// - First bit one means off, one sync pulse
// - Sleep period follows a completed off command
// - Enable low holds sleep, rising edge starts it
// - Extended clock is 8, 4, 2, 1 base periods

module rbc_top #(
    parameter int SLEEP_UNIT_CYC = `RBC_SLEEP_UNIT_CYC
) (
    input  wire logic        sys_clk_i,
    input  wire logic        resetn_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [15:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [15:0] rd_data_o,
    input  wire logic        dem_i,
    input  wire logic        enable_i,
    input  wire logic        data_i,
    output logic             data_o,
    output logic             data_oe_o,
    output logic             rx_mode_o,
    output logic             active_o
);
    rbc_pkg::rbc_state_t state_q;

    logic [1:0]  baud_range_select_q;
    logic        bit_count_sel_hi_q;
    logic        bit_count_sel_lo_q;
    logic [4:0]  sleep_q;
    logic [5:0]  lim_min_q;
    logic [5:0]  lim_max_q;

    logic        dem_s1_q;
    logic        dem_s2_q;
    logic        dem_d_q;
    logic        en_s1_q;
    logic        en_s2_q;
    logic        pin_s1_q;
    logic        pin_s2_q;

    logic        xtick_w;
    logic        dem_edge_w;
    logic [5:0]  interval_counter_value_q;
    logic [4:0]  chk_done_q;
    logic [4:0]  chk_target_w;
    logic [7:0]  tmr_q;
    logic [7:0]  ext_low_q;
    logic [19:0] sleep_cnt_q;
    logic [19:0] sleep_lim_w;

    rbc_stage_if st ();

    // ----------------------------------------
    // Input synchronisers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            dem_s1_q <= 1'b0;
            dem_s2_q <= 1'b0;
            dem_d_q  <= 1'b0;
            en_s1_q  <= 1'b1;
            en_s2_q  <= 1'b1;
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
        end else begin
            dem_s1_q <= dem_i;
            dem_s2_q <= dem_s1_q;
            dem_d_q  <= dem_s2_q;
            en_s1_q  <= enable_i;
            en_s2_q  <= en_s1_q;
            pin_s1_q <= data_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign dem_edge_w = dem_s2_q ^ dem_d_q;

    // ----------------------------------------
    // Extended clock and data stage
    // ----------------------------------------
    rbc_xclk_div u_div (
        .sys_clk_i           (sys_clk_i),
        .resetn_i            (resetn_i),
        .baud_range_select_i (baud_range_select_q),
        .xtick_o             (xtick_w)
    );

    assign st.xtick   = xtick_w;
    assign st.dem     = dem_s2_q;
    assign st.lim_min = lim_min_q;
    assign st.lim_max = lim_max_q;

    rbc_data_stage u_stage (
        .sys_clk_i (sys_clk_i),
        .resetn_i  (resetn_i),
        .st        (st.stage)
    );

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            baud_range_select_q <= `RBC_BAUD_RST;
            bit_count_sel_hi_q  <= 1'(`RBC_BITCHK_RST >> 1);
            bit_count_sel_lo_q  <= 1'(`RBC_BITCHK_RST);
            sleep_q             <= `RBC_SLEEP_RST;
            lim_min_q           <= `RBC_LIM_MIN_RST;
            lim_max_q           <= `RBC_LIM_MAX_RST;
        end else if (wr_i) begin
            if (addr_i == `RBC_ADDR_CFG) begin
                baud_range_select_q <= wr_data_i[`RBC_CFG_BAUD_LSB +: 2];
                bit_count_sel_lo_q  <= wr_data_i[`RBC_CFG_BITCHK_LSB];
                bit_count_sel_hi_q  <= wr_data_i[`RBC_CFG_BITCHK_LSB + 1];
                sleep_q             <= wr_data_i[`RBC_CFG_SLEEP_LSB +: 5];
            end else if (addr_i == `RBC_ADDR_LIM) begin
                // Software keeps min at or above 10 and max at or below 63
                lim_min_q <= wr_data_i[`RBC_LIM_MIN_LSB +: 6];
                lim_max_q <= wr_data_i[`RBC_LIM_MAX_LSB +: 6];
            end
        end
    end

    // ----------------------------------------
    // Read port, data valid one cycle only
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rd_data_o <= 16'h0000;
        end else if (rd_i) begin
            if (addr_i == `RBC_ADDR_CFG) begin
                rd_data_o <= {7'h00, sleep_q, bit_count_sel_hi_q, bit_count_sel_lo_q, baud_range_select_q};
            end else if (addr_i == `RBC_ADDR_LIM) begin
                rd_data_o <= {2'h0, lim_max_q, 2'h0, lim_min_q};
            end else if (addr_i == `RBC_ADDR_STAT) begin
                rd_data_o <= {10'h000, (state_q == rbc_pkg::ST_RECV), st.data, 1'b0, state_q};
            end else begin
                rd_data_o <= 16'h0000;
            end
        end else begin
            rd_data_o <= 16'h0000;
        end
    end

    // ----------------------------------------
    // Derived limits
    // ----------------------------------------
    assign chk_target_w = 5'({1'b0, bit_count_sel_hi_q, bit_count_sel_lo_q, 2'b00})
                        + 5'({2'b00, bit_count_sel_hi_q, bit_count_sel_lo_q, 1'b0});
    assign sleep_lim_w  = 20'(sleep_q) * 20'(SLEEP_UNIT_CYC);

    // ----------------------------------------
    // External low on the data pin
    // ----------------------------------------
    // Counted only while released, so the own low drive is not mistaken
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_low_q <= 8'h00;
        end else if (state_q != rbc_pkg::ST_RECV || pin_s2_q || data_oe_o) begin
            ext_low_q <= 8'h00;
        end else if (xtick_w && ext_low_q != 8'hFF) begin
            ext_low_q <= 8'(ext_low_q + 8'h01);
        end
    end

    // ----------------------------------------
    // Polling state machine
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_q                  <= rbc_pkg::ST_SLEEP;
            tmr_q                    <= 8'h00;
            sleep_cnt_q              <= 20'h00000;
            interval_counter_value_q <= 6'h00;
            chk_done_q               <= 5'h00;
        end else if (!en_s2_q) begin
            state_q     <= rbc_pkg::ST_SLEEP;
            sleep_cnt_q <= 20'h00000;
        end else begin
            case (state_q)
                rbc_pkg::ST_SLEEP: begin
                    // Value zero gives instant restart for enable-driven polling
                    if (sleep_q == `RBC_SLEEP_PERM) begin
                        sleep_cnt_q <= 20'h00000;
                    end else if (sleep_cnt_q >= sleep_lim_w) begin
                        state_q     <= rbc_pkg::ST_STARTUP;
                        sleep_cnt_q <= 20'h00000;
                        tmr_q       <= 8'h00;
                    end else begin
                        sleep_cnt_q <= 20'(sleep_cnt_q + 20'h00001);
                    end
                end
                rbc_pkg::ST_STARTUP: begin
                    // Demodulator output is not looked at here
                    if (xtick_w) begin
                        if (tmr_q >= `RBC_STARTUP_XCLK) begin
                            state_q                  <= rbc_pkg::ST_CHECK;
                            interval_counter_value_q <= 6'h00;
                            chk_done_q               <= 5'h00;
                        end else begin
                            tmr_q <= 8'(tmr_q + 8'h01);
                        end
                    end
                end
                rbc_pkg::ST_CHECK: begin
                    if (chk_target_w == 5'h00) begin
                        state_q <= rbc_pkg::ST_RECV;
                    end else if (interval_counter_value_q >= lim_max_q) begin
                        // First, so an edge on the limit count still fails
                        state_q <= rbc_pkg::ST_SLEEP;
                    end else if (dem_edge_w) begin
                        if (interval_counter_value_q < lim_min_q) begin
                            state_q <= rbc_pkg::ST_SLEEP;
                        end else if (5'(chk_done_q + 5'h01) >= chk_target_w) begin
                            state_q <= rbc_pkg::ST_RECV;
                        end else begin
                            chk_done_q               <= 5'(chk_done_q + 5'h01);
                            interval_counter_value_q <= 6'h00;
                        end
                    end else if (xtick_w) begin
                        interval_counter_value_q <= 6'(interval_counter_value_q + 6'h01);
                    end
                end
                rbc_pkg::ST_RECV: begin
                    // Noise on the demodulator never leaves this state
                    if (pin_s2_q && ext_low_q >= `RBC_OFF_LOW_XCLK) begin
                        state_q <= rbc_pkg::ST_OFF_GAP;
                        tmr_q   <= 8'h00;
                    end
                end
                rbc_pkg::ST_OFF_GAP: begin
                    if (xtick_w) begin
                        if (tmr_q >= `RBC_OFF_GAP_XCLK) begin
                            state_q <= rbc_pkg::ST_OFF_SYNC;
                            tmr_q   <= 8'h00;
                        end else begin
                            tmr_q <= 8'(tmr_q + 8'h01);
                        end
                    end
                end
                rbc_pkg::ST_OFF_SYNC: begin
                    if (xtick_w) begin
                        if (tmr_q >= `RBC_SYNC_XCLK) begin
                            state_q <= rbc_pkg::ST_OFF_BIT;
                            tmr_q   <= 8'h00;
                        end else begin
                            tmr_q <= 8'(tmr_q + 8'h01);
                        end
                    end
                end
                rbc_pkg::ST_OFF_BIT: begin
                    if (xtick_w) begin
                        if (tmr_q >= `RBC_OFF_TRAIL_XCLK) begin
                            // Pin held low reads as a one: off command
                            state_q     <= pin_s2_q ? rbc_pkg::ST_RECV : rbc_pkg::ST_SLEEP;
                            sleep_cnt_q <= 20'h00000;
                        end else begin
                            tmr_q <= 8'(tmr_q + 8'h01);
                        end
                    end
                end
                default: begin
                    state_q <= rbc_pkg::ST_SLEEP;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Pin drivers
    // ----------------------------------------
    // Open-drain style: only lows are driven, the pull-up makes highs
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_o    <= 1'b1;
            data_oe_o <= 1'b0;
            rx_mode_o <= 1'b0;
            active_o  <= 1'b0;
        end else begin
            rx_mode_o <= (state_q == rbc_pkg::ST_RECV);
            active_o  <= (state_q != rbc_pkg::ST_SLEEP);
            if (state_q == rbc_pkg::ST_RECV) begin
                data_o    <= st.data;
                data_oe_o <= !st.data;
            end else if (state_q == rbc_pkg::ST_OFF_SYNC) begin
                data_o    <= 1'b0;
                data_oe_o <= 1'b1;
            end else begin
                data_o    <= 1'b1;
                data_oe_o <= 1'b0;
            end
        end
    end

endmodule : rbc_top

/* verilog/rbc_params.svh */
`ifndef RBC_PARAMS_SVH
`define RBC_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define RBC_ADDR_CFG          8'h00
`define RBC_ADDR_LIM          8'h04
`define RBC_ADDR_STAT         8'h08

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RBC_CFG_BAUD_LSB      0
`define RBC_CFG_BITCHK_LSB    2
`define RBC_CFG_SLEEP_LSB     4
`define RBC_LIM_MIN_LSB       0
`define RBC_LIM_MAX_LSB       8
`define RBC_STAT_STATE_LSB    0
`define RBC_STAT_DATA_BIT     4
`define RBC_STAT_RX_BIT       5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RBC_BAUD_RST          2'h0
`define RBC_BITCHK_RST        2'h2
`define RBC_SLEEP_RST         5'h0B
`define RBC_LIM_MIN_RST       6'h0E
`define RBC_LIM_MAX_RST       6'h18
`define RBC_SLEEP_PERM        5'h1F

// ----------------------------------------
// Timing counts, in extended clock periods
// ----------------------------------------
`define RBC_STARTUP_XCLK      8'h20
`define RBC_HOLD_VALID_XCLK   8'h06
`define RBC_HOLD_INVALID_XCLK 8'h0A
`define RBC_MAX_LOW_XCLK      8'h80
`define RBC_OFF_LOW_XCLK      8'h90
`define RBC_OFF_GAP_XCLK      8'h08
`define RBC_SYNC_XCLK         8'h04
`define RBC_OFF_TRAIL_XCLK    8'h08

// Basic clock periods per sleep step
`define RBC_SLEEP_UNIT_CYC    1024

`endif

/* verilog/rbc_pkg.sv */
package rbc_pkg;

    typedef enum logic [2:0] {
        ST_SLEEP    = 3'h0,
        ST_STARTUP  = 3'h1,
        ST_CHECK    = 3'h2,
        ST_RECV     = 3'h3,
        ST_OFF_GAP  = 3'h4,
        ST_OFF_SYNC = 3'h5,
        ST_OFF_BIT  = 3'h6
    } rbc_state_t;

endpackage : rbc_pkg

/* verilog/rbc_stage_if.sv */
`timescale 1ns/1ns

interface rbc_stage_if;
    logic       xtick;
    logic       dem;
    logic [5:0] lim_min;
    logic [5:0] lim_max;
    logic       data;

    modport ctrl  (output xtick, output dem, output lim_min, output lim_max, input data);
    modport stage (input xtick, input dem, input lim_min, input lim_max, output data);
endinterface : rbc_stage_if

/* verilog/rbc_xclk_div.sv */
`timescale 1ns/1ns

module rbc_xclk_div (
    input  wire logic       sys_clk_i,
    input  wire logic       resetn_i,
    input  wire logic [1:0] baud_range_select_i,
    output logic            xtick_o
);
    logic [2:0] cnt_q;
    logic [2:0] last_w;

    // ----------------------------------------
    // Divide by 8, 4, 2 or 1
    // ----------------------------------------
    assign last_w = 3'(3'h7 >> baud_range_select_i);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt_q   <= 3'h0;
            xtick_o <= 1'b0;
        end else if (cnt_q >= last_w) begin
            cnt_q   <= 3'h0;
            xtick_o <= 1'b1;
        end else begin
            cnt_q   <= 3'(cnt_q + 3'h1);
            xtick_o <= 1'b0;
        end
    end
endmodule : rbc_xclk_div

/* verilog/rbc_data_stage.sv */
`timescale 1ns/1ns
`include "rbc_params.svh"

module rbc_data_stage (
    input  wire logic  sys_clk_i,
    input  wire logic  resetn_i,
    rbc_stage_if.stage st
);
    logic       data_q;
    logic [7:0] hold_q;
    logic [7:0] need_q;
    logic       in_win_w;

    assign st.data  = data_q;
    assign in_win_w = (hold_q >= {2'h0, st.lim_min}) && (hold_q < {2'h0, st.lim_max});

    // ----------------------------------------
    // Debounce and low-time limiter
    // ----------------------------------------
    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            data_q <= 1'b1;
            hold_q <= 8'h00;
            need_q <= `RBC_HOLD_INVALID_XCLK;
        end else if (st.xtick) begin
            if (st.dem != data_q && hold_q >= need_q) begin
                data_q <= st.dem;
                hold_q <= 8'h01;
                need_q <= in_win_w ? `RBC_HOLD_VALID_XCLK : `RBC_HOLD_INVALID_XCLK;
            end else if (!data_q && hold_q >= `RBC_MAX_LOW_XCLK) begin
                // Released high so the pin is free for commands
                data_q <= 1'b1;
                hold_q <= 8'h01;
                need_q <= `RBC_HOLD_INVALID_XCLK;
            end else if (hold_q != 8'hFF) begin
                hold_q <= 8'(hold_q + 8'h01);
            end
        end
    end
endmodule : rbc_data_stage

/* tb/rbc_top_sva.sv */
`timescale 1ns/1ns
`include "rbc_params.svh"

module rbc_top_sva (
    input wire logic        sys_clk_i,
    input wire logic        resetn_i,
    input wire logic        rd_i,
    input wire logic [15:0] rd_data_o,
    input wire logic        enable_i,
    input wire logic        data_i,
    input wire logic        data_o,
    input wire logic        data_oe_o,
    input wire logic        rx_mode_o,
    input wire logic        active_o
);
    // Slowest tick is 8 clocks; margin for sync and hold
    localparam int MAX_LOW_CYC = `RBC_MAX_LOW_XCLK * 8 + 16;
    logic [11:0] low_cnt_q;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!resetn_i);

    always_ff @(posedge sys_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt_q <= 12'h000;
        end else if (data_oe_o) begin
            low_cnt_q <= low_cnt_q + 12'h001;
        end else begin
            low_cnt_q <= 12'h000;
        end
    end

    // ------------------------------
    // Sequences
    // ------------------------------
    sequence s_enable_held;
        !enable_i [*6];
    endsequence
    sequence s_pin_quiet;
        (rx_mode_o && enable_i && data_i) [*8];
    endsequence

    // ------------------------------
    // Properties
    // ------------------------------
    a_oe_means_low: assert property (data_oe_o |-> !data_o)
        else $error("data pin driven while high");
    a_rx_from_check: assert property ($rose(rx_mode_o) |-> $past(active_o))
        else $error("receive entered from sleep");
    a_sleep_released: assert property (!active_o && !$past(active_o) |-> !data_oe_o)
        else $error("data pin driven in sleep");
    a_enable_sleep: assert property (s_enable_held |-> !active_o && !rx_mode_o)
        else $error("not asleep while enable low");
    a_rx_stays: assert property (s_pin_quiet |=> rx_mode_o)
        else $error("receive left without command");
    a_max_low: assert property (low_cnt_q <= MAX_LOW_CYC)
        else $error("data low too long");
    a_hold_level: assert property (rx_mode_o && $changed(data_o) |=> ($stable(data_o) || !rx_mode_o) [*5])
        else $error("data level not held");
    a_rd_idle: assert property (!rd_i |=> rd_data_o == 16'h0000)
        else $error("read data outside read cycle");
endmodule : rbc_top_sva

/* tb/rbc_mcu_model.sv */
`timescale 1ns/1ns

module rbc_mcu_model (
    input  wire logic sys_clk_i,
    input  wire logic pin_i,
    output logic      pull_o,
    output logic      enable_o
);
    initial begin
        pull_o   = 1'b0;
        enable_o = 1'b0;
    end

    task set_enable(input logic v);
        @(posedge sys_clk_i) enable_o <= v;
    endtask : set_enable

    // Long low, wait for the sync pulse, then answer with the given bit
    task send_off(input int n, input logic one, output logic ok);
        int k;
        ok = 1'b0;
        @(posedge sys_clk_i) pull_o <= 1'b1;
        repeat (n) @(posedge sys_clk_i);
        pull_o <= 1'b0;
        for (k = 0; k < 60 && !ok; k++) begin
            @(posedge sys_clk_i);
            ok = !pin_i;
        end
        for (k = 0; k < 20 && !pin_i; k++) begin
            @(posedge sys_clk_i);
        end
        pull_o <= one;
        repeat (12) @(posedge sys_clk_i);
        pull_o <= 1'b0;
    endtask : send_off
endmodule : rbc_mcu_model

/* tb/rbc_top_test.sv */
`timescale 1ns/1ns

module rbc_top_test;
    logic        sys_clk;
    logic        resetn;
    logic [7:0]  addr;
    logic [15:0] wr_data;
    logic        wr;
    logic        rd;
    logic [15:0] rd_data;
    logic        dem;
    logic        enable;
    logic        pull;
    logic        pin;
    logic        data_o;
    logic        data_oe;
    logic        rx_mode;
    logic        active;
    logic [2:0]  mon;
    logic        oe_prev = 1'b0;
    int          oe_rises = 0;
    int          bad_count = 0;
    int          total_checks = 0;

    // Open drain pin with pull-up
    assign pin = !(data_oe || pull);
    assign mon = {data_o, active, rx_mode};

    rbc_top #(.SLEEP_UNIT_CYC(4)) i_dut (
        .sys_clk_i(sys_clk), .resetn_i(resetn), .addr_i(addr), .wr_data_i(wr_data),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rd_data), .dem_i(dem), .enable_i(enable),
        .data_i(pin), .data_o(data_o), .data_oe_o(data_oe), .rx_mode_o(rx_mode), .active_o(active));
    rbc_mcu_model i_mcu (.sys_clk_i(sys_clk), .pin_i(pin), .pull_o(pull), .enable_o(enable));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        oe_prev <= data_oe;
        if (data_oe && !oe_prev) oe_rises <= oe_rises + 1;
    end

    // ------------------------------
    // Helpers
    // ------------------------------
    task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task end_sim;
        if (bad_count == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim

    task bus_wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        addr    <= a;
        wr_data <= d;
        wr      <= 1'b1;
        @(posedge sys_clk);
        wr      <= 1'b0;
    endtask : bus_wr

    task bus_rd(input logic [7:0] a, output logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk);
        rd   <= 1'b0;
        @(negedge sys_clk);
        d = rd_data;
    endtask : bus_rd

    task wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (mon[k] !== v && n < lim);
        if (mon[k] !== v) begin
            bad_count++;
            $display("ERROR wait_%0d expected %b seen %b", k, v, mon[k]);
            end_sim();
        end
    endtask : wait_for

    task dem_flip(input int gap);
        repeat (gap) @(posedge sys_clk);
        dem <= !dem;
    endtask : dem_flip

    // Baud 3 (tick per clock), sleep 2; returns near the start of checking
    task start_check(input logic [1:0] sel);
        int n;
        i_mcu.set_enable(1'b0);
        wait_for(1, 1'b0, 20, n);
        bus_wr(8'h00, {7'h00, 5'h02, sel, 2'h3});
        i_mcu.set_enable(1'b1);
        wait_for(1, 1'b1, 40, n);
        repeat (6) dem_flip(3);
        repeat (15) @(posedge sys_clk);
    endtask : start_check

    task go_rx(input logic [1:0] sel);
        int i, n;
        start_check(sel);
        if (sel != 2'h0) begin
            for (i = 1; i < 6 * sel; i++) dem_flip(18);
            @(negedge sys_clk);
            chk("rx_early", {15'h0, rx_mode}, 16'h0000);
            dem_flip(18);
        end
        wait_for(0, 1'b1, 45, n);
    endtask : go_rx

    // ------------------------------
    // Scenarios
    // ------------------------------
    task t_regs;
        logic [15:0] d;
        bus_rd(8'h04, d);
        chk("lim_reset", d, 16'h180E);
        bus_rd(8'h00, d);
        chk("cfg_reset", d, 16'h00B8);
        bus_wr(8'h04, 16'h140A);
        bus_rd(8'h04, d);
        chk("lim_write", d, 16'h140A);
        bus_wr(8'h04, 16'h180E);
        bus_wr(8'h08, 16'hFFFF);
        bus_rd(8'h0C, d);
        chk("unmapped", d, 16'h0000);
    endtask : t_regs

    task t_baud;
        int b, n, f;
        for (b = 0; b < 4; b++) begin
            i_mcu.set_enable(1'b0);
            wait_for(1, 1'b0, 20, n);
            bus_wr(8'h00, {7'h00, 5'h02, 2'h1, 2'(b)});
            i_mcu.set_enable(1'b1);
            wait_for(1, 1'b1, 40, n);
            wait_for(1, 1'b0, 600, n);
            f = 8 >> b;
            chk("active_len", 16'(n >= 55 * f && n <= 59 * f + 6), 16'h0001);
        end
    endtask : t_baud

    task t_window;
        int   gaps[4] = '{15, 24, 14, 25};
        logic pass[4] = '{1'b1, 1'b1, 1'b0, 1'b0};
        int   i;
        for (i = 0; i < 4; i++) begin
            start_check(2'h1);
            dem_flip(18);
            dem_flip(gaps[i]);
            repeat (6) @(negedge sys_clk);
            chk("window", {15'h0, active}, {15'h0, pass[i]});
        end
    endtask : t_window

    task t_rx;
        logic [15:0] d;
        int          i, n;
        bus_rd(8'h08, d);
        chk("stat_rx", d & 16'h003F, 16'h0033);
        dem_flip(1);
        dem_flip(2);
        wait_for(2, 1'b0, 10, n);
        repeat (8) @(negedge sys_clk);
        chk("hold", {15'h0, data_o}, 16'h0000);
        wait_for(2, 1'b1, 20, n);
        for (i = 0; i < 20; i++) dem_flip(4);
        repeat (30) @(negedge sys_clk);
        chk("rx_noise", {15'h0, rx_mode}, 16'h0001);
        dem_flip(1);
        wait_for(2, 1'b0, 20, n);
        wait_for(2, 1'b1, 200, n);
        chk("max_low", 16'(n >= 126 && n <= 131), 16'h0001);
        dem_flip(1);
    endtask : t_rx

    task t_off;
        int   base, n;
        logic ok;
        bus_wr(8'h00, {7'h00, 5'h0A, 2'h3, 2'h3});
        i_mcu.send_off(150, 1'b0, ok);
        chk("zero_sync", {15'h0, ok}, 16'h0001);
        @(negedge sys_clk);
        chk("zero_stays", {15'h0, rx_mode}, 16'h0001);
        base = oe_rises;
        i_mcu.send_off(150, 1'b1, ok);
        chk("sync_seen", {15'h0, ok}, 16'h0001);
        wait_for(1, 1'b0, 20, n);
        chk("sync_count", 16'(oe_rises - base), 16'h0001);
        wait_for(1, 1'b1, 60, n);
        chk("sleep_len", 16'(n >= 25 && n <= 43), 16'h0001);
    endtask : t_off

    task t_enable;
        int n;
        go_rx(2'h1);
        i_mcu.set_enable(1'b0);
        repeat (10) @(negedge sys_clk);
        chk("doze", {14'h0, active, rx_mode}, 16'h0000);
        repeat (50) @(negedge sys_clk);
        chk("doze_held", {14'h0, active, rx_mode}, 16'h0000);
        i_mcu.set_enable(1'b1);
        wait_for(1, 1'b1, 30, n);
        chk("wake_len", 16'(n >= 8 && n <= 15), 16'h0001);
        bus_wr(8'h00, {7'h00, 5'h00, 2'h1, 2'h3});
        i_mcu.set_enable(1'b0);
        repeat (8) @(negedge sys_clk);
        i_mcu.set_enable(1'b1);
        wait_for(1, 1'b1, 30, n);
        chk("wake_now", 16'(n >= 4 && n <= 6), 16'h0001);
    endtask : t_enable

    initial begin
        resetn  = 1'b0;
        addr    = 8'h00;
        wr_data = 16'h0000;
        wr      = 1'b0;
        rd      = 1'b0;
        dem     = 1'b1;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        t_regs();
        t_baud();
        t_window();
        go_rx(2'h0);
        go_rx(2'h1);
        go_rx(2'h2);
        go_rx(2'h3);
        t_rx();
        t_off();
        t_enable();
        end_sim();
    end
endmodule : rbc_top_test

bind rbc_top rbc_top_sva i_sva (
    .sys_clk_i(sys_clk_i), .resetn_i(resetn_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .enable_i(enable_i), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o),
    .rx_mode_o(rx_mode_o), .active_o(active_o));
